// [hdl/rx_sync_device.sv]
// Receive framer timing end: line framing, backplane alignment, register slave
`default_nettype none
module rx_sync_device (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_LINE_CLK,
  input wire logic RX_LINE_POS,
  input wire logic RX_LINE_NEG,
  rx_sync_if.device LINK
);
  // ****************************************
  // State types, one per clock domain
  // ****************************************
  typedef struct packed {
    logic [6:0] cfg;
    logic [31:0] prdata;
    logic [2:0] tog_s;
    logic tog;
    logic [2:0] lock_s;
    logic lock;
  } reg_st_t;
  typedef struct packed {
    logic [6:0] cfg_s1;
    logic [6:0] cfg_s2;
    logic [6:0] cfg_s3;
    logic [6:0] cfg;
    logic [8:0] bit_cnt;
    logic [3:0] frm;
    logic ser;
    logic fsync;
    logic msync;
    logic syncp;
    logic ftog;
  } line_st_t;
  typedef struct packed {
    logic [6:0] cfg_s1;
    logic [6:0] cfg_s2;
    logic [6:0] cfg_s3;
    logic [6:0] cfg;
    logic [2:0] ser_s;
    logic ser;
    logic [2:0] sync_s;
    logic sync;
    logic [8:0] bit_cnt;
    logic [3:0] frm;
    logic msync;
    logic lock;
  } bp_st_t;
  reg_st_t r_q, r_d;
  line_st_t l_q, l_d;
  bp_st_t b_q, b_d;
  logic addr_ok;
  logic [8:0] l_flen, b_flen;
  logic [3:0] l_mfl, b_mfl, l_mff, b_mff;
  logic l_sig;
  logic b_active;

  // ****************************************
  // Register slave on the system clock
  // ****************************************
  assign addr_ok = (PADDR == rx_sync_pkg::RX_IO_CONFIG_OFFSET) || (PADDR == rx_sync_pkg::RX_STATUS_OFFSET);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = r_q.prdata;

  // Register next state, read data latched in setup phase
  always_comb begin
    r_d = r_q;
    r_d.tog_s = {r_q.tog_s[1:0], l_q.ftog};
    if (r_q.tog_s[1] == r_q.tog_s[2]) begin
      r_d.tog = r_q.tog_s[2];
    end
    r_d.lock_s = {r_q.lock_s[1:0], b_q.lock};
    if (r_q.lock_s[1] == r_q.lock_s[2]) begin
      r_d.lock = r_q.lock_s[2];
    end
    if (PSEL && !PENABLE) begin
      r_d.prdata = 32'h0000_0000;
      if (PADDR == rx_sync_pkg::RX_IO_CONFIG_OFFSET) begin
        r_d.prdata[6:0] = r_q.cfg;
      end else if (PADDR == rx_sync_pkg::RX_STATUS_OFFSET) begin
        r_d.prdata[rx_sync_pkg::STAT_FRAME_TOGGLE_BIT] = r_q.tog;
        r_d.prdata[rx_sync_pkg::STAT_BP_LOCK_BIT] = r_q.lock;
      end
    end
    if (PSEL && PENABLE && PWRITE && (PADDR == rx_sync_pkg::RX_IO_CONFIG_OFFSET)) begin
      r_d.cfg = PWDATA[6:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r_q <= '0;
      r_q.cfg <= rx_sync_pkg::CFG_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Line side framer on the recovered line clock
  // ****************************************
  assign l_flen = l_q.cfg[rx_sync_pkg::CFG_E1_BIT] ? rx_sync_pkg::E1_FRAME_BITS : rx_sync_pkg::T1_FRAME_BITS;
  assign l_mfl = l_q.cfg[rx_sync_pkg::CFG_E1_BIT] ? rx_sync_pkg::E1_MF_FRAMES : rx_sync_pkg::T1_MF_FRAMES;
  // Multiframe kind: CRC-4 when select set in E1
  assign l_mff = (l_q.cfg[rx_sync_pkg::CFG_E1_BIT] && l_q.cfg[rx_sync_pkg::CFG_MF_TYPE_BIT]) ?
    rx_sync_pkg::E1_CRC4_MF_FRAME : 4'h0;

  // Counters, pulses and serial bit
  always_comb begin
    l_d = l_q;
    l_sig = 1'b0;
    l_d.cfg_s1 = r_q.cfg;
    l_d.cfg_s2 = l_q.cfg_s1;
    l_d.cfg_s3 = l_q.cfg_s2;
    if (l_q.cfg_s2 == l_q.cfg_s3) begin
      l_d.cfg = l_q.cfg_s3;
    end
    l_d.bit_cnt = l_q.bit_cnt + 9'h001;
    if (l_d.bit_cnt >= l_flen) begin
      l_d.bit_cnt = 9'h000;
      l_d.frm = l_q.frm + 4'h1;
      if (l_d.frm == l_mfl) begin
        l_d.frm = 4'h0;
      end
    end
    l_d.ser = RX_LINE_POS || RX_LINE_NEG;
    l_d.fsync = (l_d.bit_cnt == 9'h000);
    l_d.msync = (l_d.bit_cnt == 9'h000) && (l_d.frm == l_mff);
    if (l_d.fsync) begin
      l_d.ftog = !l_q.ftog;
    end
    l_sig = (l_d.frm == rx_sync_pkg::T1_SIG_FRAME_A) || (l_d.frm == rx_sync_pkg::T1_SIG_FRAME_B);
    if (l_q.cfg[rx_sync_pkg::CFG_E1_BIT]) begin
      l_d.syncp = l_d.msync;
    end else begin
      l_d.syncp = l_d.fsync || (l_q.cfg[rx_sync_pkg::CFG_DOUBLE_WIDE_BIT] && l_sig && (l_d.bit_cnt == 9'h001));
    end
  end

  always_ff @(posedge RX_LINE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************
  // Backplane side, shared clock of all channels
  // ****************************************
  assign b_active = b_q.cfg[rx_sync_pkg::CFG_ES_BIT] || b_q.cfg[rx_sync_pkg::CFG_IBO_BIT];
  assign b_flen = b_q.cfg[rx_sync_pkg::CFG_E1_BIT] ? rx_sync_pkg::E1_FRAME_BITS : rx_sync_pkg::T1_FRAME_BITS;
  assign b_mfl = b_q.cfg[rx_sync_pkg::CFG_E1_BIT] ? rx_sync_pkg::E1_MF_FRAMES : rx_sync_pkg::T1_MF_FRAMES;
  assign b_mff = (b_q.cfg[rx_sync_pkg::CFG_E1_BIT] && b_q.cfg[rx_sync_pkg::CFG_MF_TYPE_BIT]) ?
    rx_sync_pkg::E1_CRC4_MF_FRAME : 4'h0;

  // Retimed data and multiframe position on the backplane clock
  always_comb begin
    b_d = b_q;
    b_d.cfg_s1 = r_q.cfg;
    b_d.cfg_s2 = b_q.cfg_s1;
    b_d.cfg_s3 = b_q.cfg_s2;
    if (b_q.cfg_s2 == b_q.cfg_s3) begin
      b_d.cfg = b_q.cfg_s3;
    end
    b_d.ser_s = {b_q.ser_s[1:0], l_q.ser};
    if (b_q.ser_s[1] == b_q.ser_s[2]) begin
      b_d.ser = b_q.ser_s[2];
    end
    // Sync pin through three flops, level taken once two agree
    b_d.sync_s = {b_q.sync_s[1:0], LINK.rx_sync_pin};
    if (b_q.sync_s[1] == b_q.sync_s[2]) begin
      b_d.sync = b_q.sync_s[2];
    end
    if (!b_active) begin
      // Idle unless store or interleaved bus is on
      b_d.bit_cnt = 9'h000;
      b_d.frm = 4'h0;
      b_d.msync = 1'b0;
      b_d.lock = 1'b0;
    end else begin
      b_d.bit_cnt = b_q.bit_cnt + 9'h001;
      if (b_d.bit_cnt >= b_flen) begin
        b_d.bit_cnt = 9'h000;
        b_d.frm = b_q.frm + 4'h1;
        if (b_d.frm == b_mfl) begin
          b_d.frm = 4'h0;
        end
      end
      // Sync pulse input marks a multiframe boundary
      if (b_q.cfg[rx_sync_pkg::CFG_ES_BIT] && !b_q.cfg[rx_sync_pkg::CFG_SYNC_DIR_BIT] &&
          b_d.sync && !b_q.sync) begin
        b_d.bit_cnt = 9'h000;
        b_d.frm = b_mff;
        b_d.lock = 1'b1;
      end
      b_d.msync = (b_d.bit_cnt == 9'h000) && (b_d.frm == b_mff);
    end
  end

  always_ff @(posedge LINK.rx_backplane_clock or negedge RST_B) begin
    if (!RST_B) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  // ****************************************
  // Link outputs
  // ****************************************
  // Data source follows the active clock
  assign LINK.rx_serial_out = (r_q.cfg[rx_sync_pkg::CFG_ES_BIT] || r_q.cfg[rx_sync_pkg::CFG_IBO_BIT]) ?
    b_q.ser : l_q.ser;
  // Dual pin: frame pulse or multiframe pulse
  assign LINK.rx_multiframe_sync_out = r_q.cfg[rx_sync_pkg::CFG_MF_ON_DUAL_BIT] ?
    (r_q.cfg[rx_sync_pkg::CFG_ES_BIT] ? b_q.msync : l_q.msync) : l_q.fsync;
  assign LINK.dev_sync_o = l_q.syncp;
  assign LINK.dev_sync_oe = r_q.cfg[rx_sync_pkg::CFG_SYNC_DIR_BIT];
endmodule
`default_nettype wire

// [shared/rx_sync_pkg.sv]
// Constants shared by the receive backplane timing ends
// How it works
// - Line data recovered, clocked by line clock
// - Serial data launched on line clock rise
// - Elastic store or interleaved bus uses backplane
// - Backplane supplies clock at supported rate
// - Backplane clock used only when store or interleaved bus enabled
// - Backplane holds clock low without store
// - Interleaved bus needs E1-multiple backplane clock
// - One backplane clock serves all channels
// - Sync pin input aligns backplane side when store enabled
// - T1 sync output double-wide on signaling frames
// - E1 sync output marks multiframe boundaries
// - Sync pin input after reset; bit 2
// - Frame sync pulse one line clock wide
// - Multiframe pulse width follows backplane clock only with store enabled, line clock otherwise
// - Store enabled: multiframe from backplane side
// - Bit 1 picks CRC-4 or signaling multiframe
// - Frame length follows T1 or E1 rate
`default_nettype none
package rx_sync_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] RX_IO_CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] RX_STATUS_OFFSET = 8'h04;
  localparam int CFG_E1_BIT = 0;
  localparam int CFG_MF_TYPE_BIT = 1;
  localparam int CFG_SYNC_DIR_BIT = 2;
  localparam int CFG_ES_BIT = 3;
  localparam int CFG_IBO_BIT = 4;
  localparam int CFG_DOUBLE_WIDE_BIT = 5;
  localparam int CFG_MF_ON_DUAL_BIT = 6;
  localparam int CFG_WIDTH = 7;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam int STAT_FRAME_TOGGLE_BIT = 0;
  localparam int STAT_BP_LOCK_BIT = 1;
  // ****************************************
  // Frame structure
  // ****************************************
  localparam logic [8:0] T1_FRAME_BITS = 9'h0C1;
  localparam logic [8:0] E1_FRAME_BITS = 9'h100;
  localparam logic [3:0] T1_MF_FRAMES = 4'hC;
  localparam logic [3:0] E1_MF_FRAMES = 4'h0;
  localparam logic [3:0] E1_CRC4_MF_FRAME = 4'h8;
  localparam logic [3:0] T1_SIG_FRAME_A = 4'h5;
  localparam logic [3:0] T1_SIG_FRAME_B = 4'hB;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 200000;
  localparam int BP_CLOCK_KHZ = 2048;
  localparam logic [7:0] BP_HALF_CYCLES = 8'(CLK_KHZ / (2 * BP_CLOCK_KHZ));
endpackage
`default_nettype wire

// [shared/rx_sync_if.sv]
// Link between the receive framer end and the backplane end
`default_nettype none
interface rx_sync_if;
  logic rx_backplane_clock;
  logic rx_serial_out;
  logic rx_multiframe_sync_out;
  logic dev_sync_o;
  logic dev_sync_oe;
  logic host_sync_o;
  logic host_sync_oe;
  logic rx_sync_pin;
  // Resolved level of the shared sync pin
  assign rx_sync_pin = dev_sync_oe ? dev_sync_o : (host_sync_oe ? host_sync_o : 1'b0);
  modport device (input rx_backplane_clock, rx_sync_pin, output rx_serial_out, rx_multiframe_sync_out,
    dev_sync_o, dev_sync_oe);
  modport host (output rx_backplane_clock, host_sync_o, host_sync_oe, input rx_serial_out,
    rx_multiframe_sync_out, rx_sync_pin);
endinterface
`default_nettype wire

// [hdl/rx_sync_backplane.sv]
// Backplane end: backplane clock divider, sync pulse source, data capture
`default_nettype none
module rx_sync_backplane (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ES_ENABLE,
  input wire logic E1_MODE,
  input wire logic DRIVE_SYNC,
  output logic RX_DATA,
  output logic RX_DATA_VALID,
  output logic MF_EVENT,
  output logic SYNC_EVENT,
  rx_sync_if.host LINK
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] div;
    logic clk;
    logic [8:0] bit_cnt;
    logic [3:0] frm;
    logic sync_o;
    logic data;
    logic data_v;
    logic mf_prev;
    logic mf_ev;
    logic [2:0] sy_s;
    logic sy;
    logic sy_ev;
  } host_st_t;
  host_st_t h_q, h_d;
  logic [8:0] flen;
  logic [3:0] mfl;

  assign flen = E1_MODE ? rx_sync_pkg::E1_FRAME_BITS : rx_sync_pkg::T1_FRAME_BITS;
  assign mfl = E1_MODE ? rx_sync_pkg::E1_MF_FRAMES : rx_sync_pkg::T1_MF_FRAMES;

  // Divider, bit position and sampling at the falling point
  always_comb begin
    h_d = h_q;
    h_d.data_v = 1'b0;
    h_d.mf_ev = 1'b0;
    h_d.sy_ev = 1'b0;
    h_d.sy_s = {h_q.sy_s[1:0], LINK.rx_sync_pin};
    if (h_q.sy_s[1] == h_q.sy_s[2]) begin
      h_d.sy = h_q.sy_s[2];
      h_d.sy_ev = h_q.sy_s[2] && !h_q.sy;
    end
    if (!ES_ENABLE) begin
      h_d.div = 8'h00;
      h_d.clk = 1'b0;
      h_d.bit_cnt = flen - 9'h001;
      h_d.frm = mfl - 4'h1;
      h_d.sync_o = 1'b0;
    end else if (h_q.div == rx_sync_pkg::BP_HALF_CYCLES - 8'h01) begin
      h_d.div = 8'h00;
      h_d.clk = !h_q.clk;
      if (!h_q.clk && !DRIVE_SYNC) begin
        // Wait at multiframe end, so the first pulse follows at once
        h_d.bit_cnt = flen - 9'h001;
        h_d.frm = mfl - 4'h1;
      end else if (!h_q.clk) begin
        // Rising edge: next bit position
        h_d.bit_cnt = h_q.bit_cnt + 9'h001;
        if (h_d.bit_cnt >= flen) begin
          h_d.bit_cnt = 9'h000;
          h_d.frm = h_q.frm + 4'h1;
          if (h_d.frm == mfl) begin
            h_d.frm = 4'h0;
          end
        end
      end else begin
        // Sync moves at the falling point, two periods wide for the far synchroniser
        h_d.sync_o = (h_q.bit_cnt <= 9'h001) && (h_q.frm == 4'h0);
        h_d.data = LINK.rx_serial_out;
        h_d.data_v = 1'b1;
        h_d.mf_prev = LINK.rx_multiframe_sync_out;
        h_d.mf_ev = LINK.rx_multiframe_sync_out && !h_q.mf_prev;
      end
    end else begin
      h_d.div = h_q.div + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  assign LINK.rx_backplane_clock = h_q.clk;
  assign LINK.host_sync_o = h_q.sync_o;
  assign LINK.host_sync_oe = DRIVE_SYNC && ES_ENABLE;
  assign RX_DATA = h_q.data;
  assign RX_DATA_VALID = h_q.data_v;
  assign MF_EVENT = h_q.mf_ev;
  assign SYNC_EVENT = h_q.sy_ev;
endmodule
`default_nettype wire

// [tb/rx_sync_sva.sv]
// Link checker for the receive backplane timing ends
`default_nettype none
module rx_sync_sva (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic rx_backplane_clock,
  input wire logic rx_multiframe_sync_out,
  input wire logic dev_sync_o,
  input wire logic dev_sync_oe,
  input wire logic host_sync_o,
  input wire logic host_sync_oe,
  input wire logic rx_sync_pin
);
  // ****************************************
  // High-time counters
  // ****************************************
  logic [7:0] bp_q, mf_q, hs_q, ds_q;
  // Count consecutive high samples
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bp_q <= 8'h00;
      mf_q <= 8'h00;
      hs_q <= 8'h00;
      ds_q <= 8'h00;
    end else begin
      bp_q <= rx_backplane_clock ? bp_q + 8'h01 : 8'h00;
      mf_q <= rx_multiframe_sync_out ? mf_q + 8'h01 : 8'h00;
      hs_q <= host_sync_o ? hs_q + 8'h01 : 8'h00;
      ds_q <= dev_sync_o ? ds_q + 8'h01 : 8'h00;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_one_driver;
    @(posedge CLK) disable iff (!RST_B) !(dev_sync_oe && host_sync_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive sync pin");
  property p_hs_width;
    @(posedge CLK) disable iff (!RST_B) $fell(rx_sync_pin) && host_sync_oe |-> hs_q == 8'hC0;
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("host sync pulse not two periods wide");
  property p_bp_half;
    @(posedge CLK) disable iff (!RST_B) bp_q <= rx_sync_pkg::BP_HALF_CYCLES;
  endproperty
  a_bp_half: assert property (p_bp_half) else $error("backplane clock high too long");
  property p_mf_bp;
    @(posedge rx_backplane_clock) disable iff (!RST_B) $rose(rx_multiframe_sync_out) |=> !rx_multiframe_sync_out;
  endproperty
  a_mf_bp: assert property (p_mf_bp) else $error("multiframe pulse wider than one period");
  property p_mf_max;
    @(posedge CLK) disable iff (!RST_B) mf_q <= 8'h60;
  endproperty
  a_mf_max: assert property (p_mf_max) else $error("multiframe pulse too long");
  property p_ds_max;
    @(posedge CLK) disable iff (!RST_B) ds_q <= 8'h14;
  endproperty
  a_ds_max: assert property (p_ds_max) else $error("sync output pulse too long");
  property p_hs_max;
    @(posedge CLK) disable iff (!RST_B) hs_q <= 8'hC0;
  endproperty
  a_hs_max: assert property (p_hs_max) else $error("host sync pulse too long");
  property p_dir_reset;
    @(posedge CLK) disable iff (!RST_B) $rose(RST_B) |-> !dev_sync_oe [*4];
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("sync pin not input after reset");
endmodule
`default_nettype wire

// [tb/test_rx_backplane_sync_timing.sv]
// Bench for both receive backplane timing ends
`default_nettype none
module test_rx_backplane_sync_timing;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0, RST_B = 1'b0, RX_LINE_CLK = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
  logic PREADY, PSLVERR, rxv, rxd, mfe, sev;
  logic RX_LINE_POS = 1'b0, RX_LINE_NEG = 1'b0, ES_ENABLE = 1'b0, E1_MODE = 1'b0, DRIVE_SYNC = 1'b0;
  logic [2:0] lc = 3'h0;
  int err_total = 0, n_compared = 0;
  rx_sync_if lnk();
  rx_sync_device rx_sync_device_i (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RX_LINE_CLK(RX_LINE_CLK), .RX_LINE_POS(RX_LINE_POS), .RX_LINE_NEG(RX_LINE_NEG), .LINK(lnk));
  rx_sync_backplane rx_sync_backplane_i (.CLK(CLK), .RST_B(RST_B), .ES_ENABLE(ES_ENABLE), .E1_MODE(E1_MODE),
    .DRIVE_SYNC(DRIVE_SYNC), .RX_DATA(rxd), .RX_DATA_VALID(rxv), .MF_EVENT(mfe), .SYNC_EVENT(sev), .LINK(lnk));
  rx_sync_sva rx_sync_sva_i (.CLK(CLK), .RST_B(RST_B), .rx_backplane_clock(lnk.rx_backplane_clock),
    .rx_multiframe_sync_out(lnk.rx_multiframe_sync_out), .dev_sync_o(lnk.dev_sync_o),
    .dev_sync_oe(lnk.dev_sync_oe), .host_sync_o(lnk.host_sync_o), .host_sync_oe(lnk.host_sync_oe),
    .rx_sync_pin(lnk.rx_sync_pin));
  // ****************************************
  // Clocks and line stimulus
  // ****************************************
  always #2.5 CLK = ~CLK;
  always #24 RX_LINE_CLK = ~RX_LINE_CLK;
  // Alternate marks, data changes every four bits
  always @(posedge RX_LINE_CLK) begin
    lc <= lc + 3'h1;
    RX_LINE_POS <= lc[2] & lc[0];
    RX_LINE_NEG <= lc[2] & ~lc[0];
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task results;
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h00, 32'h0000_0000, q, e);
    check("cfg reset", q, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_007F, q, e);
    apb(1'b0, 8'h00, 32'h0000_0000, q, e);
    check("cfg back", q, 32'h0000_007F);
    apb(1'b0, 8'h08, 32'h0000_0000, q, e);
    check("unmapped err", {31'h0, e}, 32'h0000_0001);
    check("unmapped data", q, 32'h0000_0000);
  endtask
  task gap_meas(input logic [31:0] cfg, input int eg);
    logic [31:0] q;
    logic e, pm, wide;
    int gap, w, n1, n2;
    gap = -1;
    w = 0;
    n1 = 0;
    n2 = 0;
    wide = 1'b0;
    apb(1'b1, 8'h00, cfg, q, e);
    repeat (20) @(negedge RX_LINE_CLK);
    pm = lnk.rx_multiframe_sync_out;
    for (int k = 0; k < 2;) begin
      @(negedge RX_LINE_CLK);
      if (gap >= 0) gap++;
      if (gap >= 0 && lnk.rx_multiframe_sync_out && pm) wide = 1'b1;
      if (lnk.dev_sync_o === 1'b1) w++;
      else if (w > 0) begin
        if (gap >= 0) n1++;
        if (gap >= 0 && w == 2) n2++;
        w = 0;
      end
      if (lnk.rx_multiframe_sync_out && !pm) k++;
      if (lnk.rx_multiframe_sync_out && !pm && k == 1) gap = 0;
      pm = lnk.rx_multiframe_sync_out;
    end
    check("pulse spacing", 32'(gap), 32'(eg));
    check("pulse wide", {31'h0, wide}, 32'h0000_0000);
    if (cfg[2]) check("sync pulses", 32'(n1), 32'h0000_000C);
    if (cfg[2]) check("double wide", 32'(n2), 32'h0000_0002);
  endtask
  task t_toggle;
    logic [31:0] q, q2;
    logic e;
    repeat (50) @(negedge RX_LINE_CLK);
    apb(1'b0, 8'h04, 32'h0000_0000, q, e);
    repeat (193) @(negedge RX_LINE_CLK);
    apb(1'b0, 8'h04, 32'h0000_0000, q2, e);
    check("frame toggle", q2, {31'h0, ~q[0]});
  endtask
  task stab(input logic bp);
    logic a;
    repeat (8) begin
      if (bp) @(negedge lnk.rx_backplane_clock);
      else @(negedge RX_LINE_CLK);
      a = lnk.rx_serial_out;
      #(bp ? 200 : 20);
      check("serial hold", {31'h0, lnk.rx_serial_out}, {31'h0, a});
    end
  endtask
  task t_store;
    logic [31:0] q;
    logic e;
    int cnt, ne, nm;
    cnt = 0;
    repeat (200) @(negedge CLK) if (lnk.rx_backplane_clock !== 1'b0) cnt++;
    check("clock held low", 32'(cnt), 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0049, q, e);
    ES_ENABLE <= 1'b1;
    E1_MODE <= 1'b1;
    repeat (10) @(posedge lnk.rx_backplane_clock);
    stab(1'b1);
    cnt = 0;
    repeat (960) @(negedge CLK) begin
      if (rxv === 1'b1) begin
        cnt++;
        check("captured bit", {31'h0, rxd}, {31'h0, lnk.rx_serial_out});
      end
    end
    check("bits per window", 32'(cnt), 32'h0000_000A);
    ne = 0;
    nm = 0;
    @(posedge CLK);
    DRIVE_SYNC <= 1'b1;
    repeat (1440) @(negedge CLK) begin
      if (sev === 1'b1) ne++;
      if (mfe === 1'b1) nm++;
    end
    check("sync events", 32'(ne), 32'h0000_0001);
    check("store multiframe", 32'(nm), 32'h0000_0001);
    apb(1'b0, 8'h04, 32'h0000_0000, q, e);
    check("locked", {31'h0, q[1]}, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0011, q, e);
    repeat (10) @(posedge lnk.rx_backplane_clock);
    stab(1'b1);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs;
    gap_meas(32'h0000_0000, 193);
    t_toggle;
    stab(1'b0);
    gap_meas(32'h0000_0001, 256);
    gap_meas(32'h0000_0064, 2316);
    t_store;
    results;
  end
  initial begin
    #450000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
